// ==== tcu_capture_unit.sv ====
// input capture unit with timebase counter and axi4-lite register slave
// Overview of operation
// - capture copies whole 16-bit timebase into pair
// - codes 0100 falling, 0101 rising edge capture
// - codes 0110 every 4th, 0111 16th rise
// - capture sets flag; only software clears it
// - newer capture overwrites value, no overrun indication
// - prescaler cleared when off or not capturing
// - every reset clears the prescaler counter
// - switching prescaler codes keeps the counter value
// - mode change may raise false flag, unsuppressed
// - quarter-rate timebase holds count during sleep
// - external timebase keeps capture working in sleep
// - pin level triggers capture regardless of direction
// - second unit picks capture pin by select bit
// - only second unit starts conversion on compare
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_capture_unit #(
  parameter bit IS_SECOND_UNIT = 1'b0 // unit identity: pin select and conversion start
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PRIMARY_PORT_PIN_I,
  input wire logic ALTERNATE_PORT_PIN_I,
  input wire logic TB_EXT_CLK_I,
  input wire logic SLEEP_I,
  output logic CAPTURE_IRQ_O,
  output logic ADC_START_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  // bus state
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  tcu_pkg::tcu_resp_t bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  tcu_pkg::tcu_resp_t rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic aw_got_r, aw_got_nxt; // write address held
  logic w_got_r, w_got_nxt; // write data held
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic wr_do; // both halves present, commit this cycle
  logic [31:0] rd_word; // read mux result
  logic rd_hit; // read address is mapped
  logic wr_hit; // write address is mapped

  // unit state
  logic [5:0] mode_ctl_r, mode_ctl_nxt; // duty low bits and mode field
  tcu_pkg::tcu_count_t cap_r, cap_nxt; // capture value pair
  logic flag_r, flag_nxt; // capture event flag
  logic ie_r, ie_nxt; // capture interrupt enable
  logic pinsel_r, pinsel_nxt; // second unit pin select
  logic extclk_r, extclk_nxt; // timebase from external source
  logic tben_r, tben_nxt; // timebase running
  tcu_pkg::tcu_count_t tb_r, tb_nxt; // timebase counter
  logic [1:0] div_r, div_nxt; // quarter rate divider
  logic irq_r, irq_nxt;
  logic adc_r, adc_nxt;
  logic pin_prev_r, pin_prev_nxt; // last synchronised pin level
  logic ext_prev_r, ext_prev_nxt; // last synchronised external clock level

  logic pin_raw; // selected capture pin, direction is irrelevant here
  logic pin_lvl;
  logic ext_lvl;
  logic pin_rise;
  logic pin_fall;
  logic cap_event;
  tcu_pkg::tcu_mode_t mode;
  logic tb_tick;

  assign mode = mode_ctl_r[3:0];
  // the pin is read as a level, so a port write driving it can capture
  assign pin_raw = (IS_SECOND_UNIT && pinsel_r) ? ALTERNATE_PORT_PIN_I
                                                 : PRIMARY_PORT_PIN_I;
  assign pin_rise = pin_lvl & ~pin_prev_r;
  assign pin_fall = ~pin_lvl & pin_prev_r;

  // capture pin synchroniser
  tcu_sync u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .async_i(pin_raw),
    .level_o(pin_lvl)
  );

  // external timebase clock synchroniser, synchronised counting only
  tcu_sync u_ext_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .async_i(TB_EXT_CLK_I),
    .level_o(ext_lvl)
  );

  // edge qualifier and prescaler
  tcu_prescale u_prescale (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .mode_i(mode),
    .rise_i(pin_rise),
    .fall_i(pin_fall),
    .capture_o(cap_event)
  );

  // read data mux, unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ARADDR_I)
      `TCU_OFS_MODE_CTL: rd_word[5:0] = mode_ctl_r;
      `TCU_OFS_CAP_LOW: rd_word[7:0] = cap_r[7:0];
      `TCU_OFS_CAP_HIGH: rd_word[7:0] = cap_r[15:8];
      `TCU_OFS_STATUS: begin
        rd_word[`TCU_STATUS_FLAG_BIT] = flag_r;
        rd_word[`TCU_STATUS_IE_BIT] = ie_r;
      end
      `TCU_OFS_CONFIG: begin
        rd_word[`TCU_CONFIG_PINSEL_BIT] = pinsel_r;
        rd_word[`TCU_CONFIG_EXTCLK_BIT] = extclk_r;
        rd_word[`TCU_CONFIG_TBEN_BIT] = tben_r;
      end
      `TCU_OFS_TIMEBASE: rd_word[15:0] = tb_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // write address decode on the held address
  always_comb begin
    case (awaddr_r)
      `TCU_OFS_MODE_CTL, `TCU_OFS_CAP_LOW, `TCU_OFS_CAP_HIGH,
      `TCU_OFS_STATUS, `TCU_OFS_CONFIG, `TCU_OFS_TIMEBASE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign wr_do = aw_got_r & w_got_r & ~bvalid_r;

  // axi4-lite channel handshakes; address and data are taken in either order
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (AWVALID_I && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = AWADDR_I;
    end
    if (WVALID_I && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = WDATA_I;
      wstrb_nxt = WSTRB_I;
    end
    if (wr_do) begin
      // unmapped writes are dropped with an error response
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end else if (bvalid_r && BREADY_I) begin
      bvalid_nxt = 1'b0;
    end
    if (ARVALID_I && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
    end else if (rvalid_r && RREADY_I) begin
      rvalid_nxt = 1'b0;
    end
    // one transfer of each kind at a time keeps the slave simple
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt = ~w_got_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // bus registers
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `TCU_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `TCU_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
    end
  end

  // timebase tick: quarter rate stalls in sleep, external edges always count
  always_comb begin
    div_nxt = div_r;
    tb_tick = 1'b0;
    if (extclk_r) begin
      tb_tick = ext_lvl & ~ext_prev_r;
    end else if (!SLEEP_I) begin
      div_nxt = div_r + 2'h1;
      tb_tick = (div_r == `TCU_TB_DIV_LAST);
    end
    if (!tben_r) begin
      tb_tick = 1'b0;
    end
  end

  // unit registers: software writes, capture loads and flag behaviour
  always_comb begin
    mode_ctl_nxt = mode_ctl_r;
    cap_nxt = cap_r;
    flag_nxt = flag_r;
    ie_nxt = ie_r;
    pinsel_nxt = pinsel_r;
    extclk_nxt = extclk_r;
    tben_nxt = tben_r;
    tb_nxt = tb_r;
    adc_nxt = 1'b0;
    pin_prev_nxt = pin_lvl;
    ext_prev_nxt = ext_lvl;
    if (tb_tick) begin
      tb_nxt = tb_r + 16'h0001;
    end
    if (wr_do && wr_hit) begin
      case (awaddr_r)
        `TCU_OFS_MODE_CTL: if (wstrb_r[0]) mode_ctl_nxt = wdata_r[5:0];
        `TCU_OFS_CAP_LOW: if (wstrb_r[0]) cap_nxt[7:0] = wdata_r[7:0];
        `TCU_OFS_CAP_HIGH: if (wstrb_r[0]) cap_nxt[15:8] = wdata_r[7:0];
        `TCU_OFS_STATUS: begin
          if (wstrb_r[0]) begin
            // writing zero clears the flag; writing one leaves it
            if (!wdata_r[`TCU_STATUS_FLAG_BIT]) flag_nxt = 1'b0;
            ie_nxt = wdata_r[`TCU_STATUS_IE_BIT];
          end
        end
        `TCU_OFS_CONFIG: begin
          if (wstrb_r[0]) begin
            pinsel_nxt = wdata_r[`TCU_CONFIG_PINSEL_BIT];
            extclk_nxt = wdata_r[`TCU_CONFIG_EXTCLK_BIT];
            tben_nxt = wdata_r[`TCU_CONFIG_TBEN_BIT];
          end
        end
        `TCU_OFS_TIMEBASE: begin
          if (wstrb_r[0]) tb_nxt[7:0] = wdata_r[7:0];
          if (wstrb_r[1]) tb_nxt[15:8] = wdata_r[15:8];
        end
        default: begin
          mode_ctl_nxt = mode_ctl_r;
        end
      endcase
    end
    // capture wins over a software write and over a flag clear in the same cycle
    if (cap_event) begin
      cap_nxt = tb_r;
      flag_nxt = 1'b1;
    end
    // compare trigger start of conversion exists only on the second unit
    if (IS_SECOND_UNIT && (mode == `TCU_MODE_CMP_TRIGGER) && (tb_r == cap_r)) begin
      adc_nxt = 1'b1;
    end
    irq_nxt = flag_nxt & ie_nxt;
  end

  // unit registers, all cleared by reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      mode_ctl_r <= `TCU_RST_MODE_CTL;
      cap_r <= `TCU_RST_CAP;
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      pinsel_r <= 1'b0;
      extclk_r <= 1'b0;
      tben_r <= 1'b0;
      tb_r <= `TCU_RST_TIMEBASE;
      div_r <= 2'h0;
      irq_r <= 1'b0;
      adc_r <= 1'b0;
      pin_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      mode_ctl_r <= mode_ctl_nxt;
      cap_r <= cap_nxt;
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      pinsel_r <= pinsel_nxt;
      extclk_r <= extclk_nxt;
      tben_r <= tben_nxt;
      tb_r <= tb_nxt;
      div_r <= div_nxt;
      irq_r <= irq_nxt;
      adc_r <= adc_nxt;
      pin_prev_r <= pin_prev_nxt;
      ext_prev_r <= ext_prev_nxt;
    end
  end

  assign AWREADY_O = awready_r;
  assign WREADY_O = wready_r;
  assign BVALID_O = bvalid_r;
  assign BRESP_O = bresp_r;
  assign ARREADY_O = arready_r;
  assign RVALID_O = rvalid_r;
  assign RRESP_O = rresp_r;
  assign RDATA_O = rdata_r;
  assign CAPTURE_IRQ_O = irq_r;
  assign ADC_START_O = adc_r;
endmodule // tcu_capture_unit

// ==== tcu_defines.svh ====
// register offsets, field positions, reset values and timing counts of the capture unit
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

// byte offsets of the register words
`define TCU_OFS_MODE_CTL 8'h00
`define TCU_OFS_CAP_LOW 8'h04
`define TCU_OFS_CAP_HIGH 8'h08
`define TCU_OFS_STATUS 8'h0C
`define TCU_OFS_CONFIG 8'h10
`define TCU_OFS_TIMEBASE 8'h14

// mode select field codes used by this unit
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_CAP_FALL 4'h4
`define TCU_MODE_CAP_RISE 4'h5
`define TCU_MODE_CAP_RISE4 4'h6
`define TCU_MODE_CAP_RISE16 4'h7
`define TCU_MODE_CMP_TRIGGER 4'hB
// capture modes share the upper code bits 01
`define TCU_MODE_CAP_GROUP 2'h1

// field positions
`define TCU_STATUS_FLAG_BIT 0
`define TCU_STATUS_IE_BIT 1
`define TCU_CONFIG_PINSEL_BIT 0
`define TCU_CONFIG_EXTCLK_BIT 1
`define TCU_CONFIG_TBEN_BIT 2

// reset values
`define TCU_RST_MODE_CTL 6'h00
`define TCU_RST_CAP 16'h0000
`define TCU_RST_TIMEBASE 16'h0000
`define TCU_RST_PRESCALE 4'h0

// prescaler terminal counts, one below the edge count
`define TCU_PRE4_LAST 4'h3
`define TCU_PRE16_LAST 4'hF

// timebase internal tick: system clock divided by four
`define TCU_TB_DIV_LAST 2'h3

// axi response codes
`define TCU_RESP_OKAY 2'h0
`define TCU_RESP_SLVERR 2'h2

`endif

// ==== tcu_pkg.sv ====
// types shared by the capture unit files
package tcu_pkg;
  typedef logic [3:0] tcu_mode_t; // mode select field value
  typedef logic [15:0] tcu_count_t; // timebase and capture value
  typedef logic [1:0] tcu_resp_t; // axi response code
endpackage

// ==== tcu_sync.sv ====
// three flop synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
module tcu_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_r; // first stage, read only by s2_r
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // the level moves only when stages two and three agree
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
  end

  // plain register stage, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;
endmodule // tcu_sync

// ==== tcu_prescale.sv ====
// capture event qualifier with edge prescaler counter
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_prescale (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tcu_pkg::tcu_mode_t mode_i,
  input wire logic rise_i,
  input wire logic fall_i,
  output logic capture_o
);
  logic [3:0] cnt_r; // rising edges seen since the last capture
  logic [3:0] cnt_nxt;
  logic cap_mode; // field selects one of the capture modes

  // count qualifying edges and flag the capturing one
  always_comb begin
    cnt_nxt = cnt_r;
    capture_o = 1'b0;
    cap_mode = (mode_i[3:2] == `TCU_MODE_CAP_GROUP);
    if (!cap_mode) begin
      // off or any non capture mode empties the counter
      cnt_nxt = `TCU_RST_PRESCALE;
    end else begin
      // moving between capture codes keeps the count, so a stray capture may follow
      case (mode_i)
        `TCU_MODE_CAP_FALL: begin
          capture_o = fall_i;
        end
        `TCU_MODE_CAP_RISE: begin
          capture_o = rise_i;
        end
        `TCU_MODE_CAP_RISE4: begin
          if (rise_i) begin
            if (cnt_r >= `TCU_PRE4_LAST) begin
              capture_o = 1'b1;
              cnt_nxt = `TCU_RST_PRESCALE;
            end else begin
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        `TCU_MODE_CAP_RISE16: begin
          if (rise_i) begin
            if (cnt_r == `TCU_PRE16_LAST) begin
              capture_o = 1'b1;
              cnt_nxt = `TCU_RST_PRESCALE;
            end else begin
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        default: begin
          capture_o = 1'b0;
        end
      endcase
    end
  end

  // counter register, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= `TCU_RST_PRESCALE;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // tcu_prescale

// ==== tcu_capture_unit_checker.sv ====
// port assertions of the capture unit and their bind
`timescale 1ns/1ps
module tcu_capture_unit_checker #(
  parameter bit IS_SECOND_UNIT = 1'b0 // unit identity, handed down from the design
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CAPTURE_IRQ_O,
  input wire logic ADC_START_O,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  // address and data taken together: the commit edge raises the response, seen one edge later
  a_write_answer_next: assert property (
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write response late");
  // a taken read address is answered at the next edge
  a_read_answer_next: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read response late");
  // a response leaves once accepted, so it is never counted twice
  a_bresp_one_shot: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write response repeated");
  a_rresp_one_shot: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read response repeated");
  // no new write or read is taken while its answer is pending
  a_write_refused: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken while response pending");
  a_read_refused: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken while response pending");
  // the write channels come back within three edges of the response handshake
  a_write_ready_back: assert property (BVALID_O && BREADY_I |-> ##[1:3] (AWREADY_O && WREADY_O))
    else $error("write channels not ready again");
  // hardware never drops the request; only a register write does, and the
  // request falls at the same edge that commits the write and raises the response
  a_irq_sw_clear: assert property (
    $fell(CAPTURE_IRQ_O) |-> BVALID_O)
    else $error("request dropped without a write");
  // the conversion start exists on the second unit only
  a_adc_second_only: assert property (
    ADC_START_O |-> IS_SECOND_UNIT)
    else $error("conversion start on first unit");
  c_slverr: cover property (BVALID_O && BRESP_O == 2'h2);
  c_irq_raised: cover property ($rose(CAPTURE_IRQ_O));
  c_adc_raised: cover property ($rose(ADC_START_O));
endmodule // tcu_capture_unit_checker

bind tcu_capture_unit tcu_capture_unit_checker #(.IS_SECOND_UNIT(IS_SECOND_UNIT))
  i_tcu_capture_unit_checker (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
  .CAPTURE_IRQ_O(CAPTURE_IRQ_O), .ADC_START_O(ADC_START_O), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I));

// ==== tcu_src.sv ====
// signal source for the capture pins and the external timebase clock
`timescale 1ns/1ps
module tcu_src (
  input wire logic clk_i,
  output logic prim_o,
  output logic alt_o,
  output logic ext_o
);
  // lines idle low; the external clock stands still between bursts
  initial {prim_o, alt_o, ext_o} = 3'h0;
  // toggles one line 2n times, each level held six cycles so the filter sees it
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      case (sel)
        0: prim_o <= !prim_o;
        1: alt_o <= !alt_o;
        default: ext_o <= !ext_o;
      endcase
      repeat (5) @(posedge clk_i);
    end
  endtask
endmodule // tcu_src

// ==== tcu_capture_unit_tb_top.sv ====
// self-checking bench of the capture unit over its register bus and pins
`timescale 1ns/1ps
`include "tcu_defines.svh"
module tcu_capture_unit_tb_top;
  localparam logic [7:0] CTL = `TCU_OFS_MODE_CTL; // register word addresses
  localparam logic [7:0] STA = `TCU_OFS_STATUS;
  localparam logic [7:0] CFG = `TCU_OFS_CONFIG;
  localparam logic [7:0] TBR = `TCU_OFS_TIMEBASE;
  localparam logic [7:0] CLO = `TCU_OFS_CAP_LOW;
  localparam logic [7:0] CHI = `TCU_OFS_CAP_HIGH;
  logic SYS_CLK_I = 1'b0; // 40 MHz system clock
  logic RESET_I = 1'b1; // held for the first four cycles
  logic SLEEP_I = 1'b0; // device asleep
  logic [7:0] AWADDR_I = 8'h00, ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0, ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CAPTURE_IRQ_O, ADC_START_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic [31:0] RDATA_O;
  logic prim, alt, ext; // pin levels from the source
  logic [31:0] rd; // last read data
  logic [1:0] rs; // last response code
  int fail_count = 0, n_tests = 0, cycles = 0;
  tcu_pkg::tcu_mode_t modes [4] = '{`TCU_MODE_CAP_FALL, `TCU_MODE_CAP_RISE,
    `TCU_MODE_CAP_RISE4, `TCU_MODE_CAP_RISE16}; // every capture code
  int edges [4] = '{1, 1, 4, 16}; // pulses needed for one capture
  always #12.5 SYS_CLK_I = ~SYS_CLK_I;
  // second unit, so the pin select and conversion start are present
  tcu_capture_unit #(.IS_SECOND_UNIT(1'b1)) i_tcu_capture_unit (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .PRIMARY_PORT_PIN_I(prim),
    .ALTERNATE_PORT_PIN_I(alt), .TB_EXT_CLK_I(ext), .SLEEP_I(SLEEP_I),
    .CAPTURE_IRQ_O(CAPTURE_IRQ_O), .ADC_START_O(ADC_START_O), .AWADDR_I(AWADDR_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(4'hF),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
    .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I));
  tcu_src i_tcu_src (.clk_i(SYS_CLK_I), .prim_o(prim), .alt_o(alt), .ext_o(ext));
  // counts a comparison and reports a mismatch at once
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    do begin
      @(posedge SYS_CLK_I);
      if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
      if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
    end while (!BVALID_O);
    rs = BRESP_O;
    BREADY_I <= 1'b0;
  endtask
  // one read; data and response land in rd and rs
  task automatic rd_bus(input logic [7:0] a);
    @(posedge SYS_CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    do begin
      @(posedge SYS_CLK_I);
      if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
    end while (!RVALID_O);
    rd = RDATA_O;
    rs = RRESP_O;
    RREADY_I <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    rd_bus(a);
    check(name, rd, exp);
  endtask
  // both capture words must hold the halves of one count
  task automatic cap_chk(input logic [15:0] v);
    rd_chk(CLO, {24'h0, v[7:0]}, "cap_low");
    rd_chk(CHI, {24'h0, v[15:8]}, "cap_high");
  endtask
  // two rises counted, then the count cleared by unit off or by reset
  task automatic presc_clear(input bit by_reset);
    wr(CTL, 32'h6);
    wr(STA, 32'h0);
    i_tcu_src.pulse(0, 2);
    if (by_reset) begin
      RESET_I <= 1'b1;
      repeat (2) @(posedge SYS_CLK_I);
      RESET_I <= 1'b0;
      repeat (2) @(posedge SYS_CLK_I);
    end else wr(CTL, 32'h0);
    wr(CTL, 32'h6);
    wr(STA, 32'h0);
    i_tcu_src.pulse(0, 3);
    rd_chk(STA, 32'h0, "count_cleared");
    i_tcu_src.pulse(0, 1);
    rd_chk(STA, 32'h1, "fourth_rise");
  endtask
  // a hang counts as a mismatch and ends the run
  always @(posedge SYS_CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge SYS_CLK_I);
    RESET_I <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    rd_chk(CTL, 32'h0, "ctl_reset");
    rd_chk(STA, 32'h0, "flag_reset");
    rd_chk(8'h18, 32'h0, "unmapped_data");
    check("unmapped_rresp", rs, `TCU_RESP_SLVERR);
    wr(8'h18, 32'h1);
    check("unmapped_bresp", rs, `TCU_RESP_SLVERR);
    wr(CTL, 32'hFF);
    rd_chk(CTL, 32'h3F, "ctl_upper");
    // timebase stopped, so each capture has a known count
    for (int i = 0; i < 4; i++) begin
      wr(CTL, 32'h0);
      wr(TBR, 32'h1000 + i);
      wr(CTL, {28'h0, modes[i]});
      wr(STA, 32'h0);
      i_tcu_src.pulse(0, edges[i] - 1);
      rd_chk(STA, 32'h0, "flag_early");
      i_tcu_src.pulse(0, 1);
      rd_chk(STA, 32'h1, "flag_set");
      cap_chk(16'h1000 + 16'(i));
    end
    wr(CTL, 32'h0);
    wr(CTL, 32'h5);
    wr(TBR, 32'h2222);
    i_tcu_src.pulse(0, 1);
    wr(TBR, 32'h3333);
    i_tcu_src.pulse(0, 1);
    cap_chk(16'h3333);
    wr(STA, 32'h1);
    rd_chk(STA, 32'h1, "flag_kept");
    wr(STA, 32'h2);
    rd_chk(STA, 32'h2, "flag_cleared");
    i_tcu_src.pulse(0, 1);
    check("irq_set", CAPTURE_IRQ_O, 1'b1);
    wr(STA, 32'h2);
    repeat (2) @(posedge SYS_CLK_I);
    check("irq_clear", CAPTURE_IRQ_O, 1'b0);
    wr(STA, 32'h0);
    presc_clear(1'b0);
    presc_clear(1'b1);
    // direct switch from fourth to sixteenth keeps the two counted rises
    wr(CTL, 32'h0);
    wr(CTL, 32'h6);
    wr(STA, 32'h0);
    i_tcu_src.pulse(0, 2);
    wr(CTL, 32'h7);
    wr(STA, 32'h0);
    i_tcu_src.pulse(0, 13);
    rd_chk(STA, 32'h0, "switch_early");
    i_tcu_src.pulse(0, 1);
    rd_chk(STA, 32'h1, "switch_kept");
    // quarter rate timebase frozen in sleep, resumes after
    wr(CTL, 32'h5);
    wr(CFG, 32'h4);
    SLEEP_I <= 1'b1;
    wr(TBR, 32'hA5C3);
    repeat (20) @(posedge SYS_CLK_I);
    i_tcu_src.pulse(0, 1);
    cap_chk(16'hA5C3);
    SLEEP_I <= 1'b0;
    repeat (40) @(posedge SYS_CLK_I);
    rd_bus(TBR);
    check("tb_resume", rd[15:0] > 16'hA5C3 && rd[15:0] < 16'hA5E0, 1'b1);
    // external timebase keeps counting and capturing in sleep
    wr(CFG, 32'h6);
    SLEEP_I <= 1'b1;
    wr(TBR, 32'h0100);
    i_tcu_src.pulse(2, 3);
    i_tcu_src.pulse(0, 1);
    cap_chk(16'h0103);
    SLEEP_I <= 1'b0;
    wr(CFG, 32'h1);
    wr(TBR, 32'h0777);
    wr(STA, 32'h0);
    i_tcu_src.pulse(0, 1);
    rd_chk(STA, 32'h0, "pin_ignored");
    i_tcu_src.pulse(1, 1);
    rd_chk(STA, 32'h1, "pin_alt");
    cap_chk(16'h0777);
    // capture pair now equals the stopped timebase
    wr(CTL, {28'h0, `TCU_MODE_CMP_TRIGGER});
    repeat (3) @(posedge SYS_CLK_I);
    check("adc_start", ADC_START_O, 1'b1);
    wr(CTL, 32'h5);
    repeat (3) @(posedge SYS_CLK_I);
    check("adc_idle", ADC_START_O, 1'b0);
    complete_run();
  end
endmodule // tcu_capture_unit_tb_top
